// File: cgpf_consts.svh
// Constants for the clock generator pin function and divider control block.
`ifndef CGPF_CONSTS_SVH
`define CGPF_CONSTS_SVH

// ----------------------------------------------------------------------------
// Field encodings
// ----------------------------------------------------------------------------
`define CGPF_ROLE_OE        2'b00
`define CGPF_ROLE_PD        2'b01
`define CGPF_ROLE_PPS       2'b10
`define CGPF_ROLE_FSEL      2'b11
`define CGPF_ROLE_RST       2'b00
`define CGPF_SLOT_RST       2'b00
`define CGPF_VCO_RST        32'h0000_0000
`define CGPF_SLOTS          4
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CGPF_CLK_MHZ        40
`define CGPF_STEP_NS        1000
`define CGPF_STEP_CYC       ((`CGPF_STEP_NS * `CGPF_CLK_MHZ) / 1000)
`define CGPF_STEP_SIZE      32'h0000_0100

`endif

// File: cgpf_ctrl.sv
// Pin function decoding, frequency slot storage and VCO stepping control.
`include "cgpf_consts.svh"

// How it works
// - Two-bit field picks the slot being programmed.
// - VCO byte writes land in the chosen slot.
// - Frequency select may also come from registers.
// - In PPS role, power-saving input swaps output to 32kHz clock.
// - Pin role field resets to output enable.
// - Byte 30 bits 6:5 set first pin role.
// - Latch high keeps serial pins as I2C.
// - Latch low, enable bit: pins are OE3/OE2.
// - Latch low, select enable: pins give select bits.
// - Latch low, no enables: serial pins unused.
// - Only PLL1 spreads; PLL2/3 seed from PLL1.
// - Frequency changes step under control, no jump.
// - Divider one: base 1/4/5/6 times 1/2/4/8.
// - Dividers two/three/five: base 1/3/5/10 times 1/2/4/5.
// - Divider four: base 1/3/5/10 times 1/2/4/8.
// - Four feedback settings; selected one drives PLL2.
// - PLL2 ramps up or down to target.
// - Clock pin level sampled at power-on.
module cgpf_ctrl
    import cgpf_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Pins
    input  wire logic        first_ctrl_pin,
    input  wire logic        scl_pin,
    input  wire logic        sda_pin,
    input  wire logic        end_dev_powerdown,
    // Configuration bits
    input  wire logic [1:0]  first_pin_role_field,
    input  wire logic        freq_select_enable,
    input  wire logic        oe23_pin_enable,
    input  wire logic [1:0]  reg_freq_select,
    input  wire logic [1:0]  slot_select,
    input  wire logic        vco_wr,
    input  wire logic [31:0] vco_wdata,
    input  wire logic        ssc_enable,
    input  wire logic [3:0]  div1_code,
    input  wire logic [3:0]  div2_code,
    input  wire logic [3:0]  div3_code,
    input  wire logic [3:0]  div4_code,
    input  wire logic [3:0]  div5_code,
    // Status and controls
    output logic             latched_pin_select,
    output cgpf_ser_role_t   serial_role,
    output logic             i2c_active,
    output logic             out1_enable,
    output logic             out2_enable,
    output logic             out3_enable,
    output logic             global_powerdown_n,
    output logic             out1_use_32k,
    output logic [1:0]       active_slot,
    output logic [31:0]      pll2_feedback,
    output logic             overshoot_limiter,
    output logic             pll1_spread_on,
    output logic             pll23_seed_pll1,
    output logic [6:0]       div1_ratio,
    output logic [6:0]       div2_ratio,
    output logic [6:0]       div3_ratio,
    output logic [6:0]       div4_ratio,
    output logic [6:0]       div5_ratio
);
    localparam int STEP_CYC = (`CGPF_STEP_CYC < 1) ? 1 : `CGPF_STEP_CYC;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    // The chain runs through reset: clearing it would make the power-on
    // latch catch a forced low instead of the real clock pin level.
    logic [3:0] sync1_r, sync2_r;
    always_ff @(posedge ref_clk) begin
        sync1_r <= {end_dev_powerdown, sda_pin, scl_pin, first_ctrl_pin};
        sync2_r <= sync1_r;
    end
    logic p_first, p_scl, p_sda, p_pd;
    assign {p_pd, p_sda, p_scl, p_first} = sync2_r;

    // ------------------------------------------------------------------------
    // Power-on latch of the clock pin level
    // ------------------------------------------------------------------------
    // The level is caught by a clocked process after release, never by reset.
    logic latch_done_r, latch_done_nxt, latch_val_r, latch_val_nxt;
    always_comb begin
        latch_done_nxt = latch_done_r;
        latch_val_nxt  = latch_val_r;
        if (!latch_done_r) begin
            latch_done_nxt = 1'b1;
            latch_val_nxt  = p_scl;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            latch_done_r <= 1'b0;
            latch_val_r  <= 1'b1;
        end else begin
            latch_done_r <= latch_done_nxt;
            latch_val_r  <= latch_val_nxt;
        end
    end
    assign latched_pin_select = latch_val_r;

    // ------------------------------------------------------------------------
    // Pin role decoding
    // ------------------------------------------------------------------------
    logic [1:0] role;
    logic [1:0] fsel_target;
    logic       fsel_active;
    // A reset-time role field must read as output enable.
    assign role = rst ? `CGPF_ROLE_RST : first_pin_role_field;

    always_comb begin
        if (latched_pin_select)
            serial_role = CGPF_SER_I2C;
        else if (oe23_pin_enable)
            serial_role = CGPF_SER_OE;
        else if (freq_select_enable)
            serial_role = CGPF_SER_FSEL;
        else
            serial_role = CGPF_SER_NONE;
    end
    assign i2c_active = (serial_role == CGPF_SER_I2C);

    always_comb begin
        out1_enable        = 1'b1;
        global_powerdown_n = 1'b1;
        out1_use_32k       = 1'b0;
        case (role)
            `CGPF_ROLE_OE:  out1_enable = p_first;
            `CGPF_ROLE_PD:  global_powerdown_n = p_first;
            `CGPF_ROLE_PPS: out1_use_32k = p_pd;
            default:        out1_enable = 1'b1;
        endcase
        out2_enable = (serial_role == CGPF_SER_OE) ? p_sda : 1'b1;
        out3_enable = (serial_role == CGPF_SER_OE) ? p_scl : 1'b1;
        fsel_active = freq_select_enable;
        if (role == `CGPF_ROLE_FSEL)
            fsel_target = {1'b0, p_first};
        else if (serial_role == CGPF_SER_FSEL)
            fsel_target = {p_scl, p_sda};
        else if (i2c_active)
            fsel_target = reg_freq_select;
        else
            fsel_target = `CGPF_SLOT_RST;
        if (!fsel_active)
            fsel_target = `CGPF_SLOT_RST;
    end

    // ------------------------------------------------------------------------
    // Frequency slot storage
    // ------------------------------------------------------------------------
    logic [31:0] slot_r [`CGPF_SLOTS];
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < `CGPF_SLOTS; i++)
                slot_r[i] <= `CGPF_VCO_RST;
        end else if (vco_wr) begin
            slot_r[slot_select] <= vco_wdata;
        end
    end

    // ------------------------------------------------------------------------
    // Controlled VCO stepping
    // ------------------------------------------------------------------------
    logic [31:0] fb_r, fb_nxt, target;
    logic [15:0] tick_r, tick_nxt;
    logic [1:0]  slot_r_act, slot_nxt;
    assign target = slot_r[fsel_target];

    always_comb begin
        fb_nxt   = fb_r;
        tick_nxt = tick_r;
        slot_nxt = fsel_target;
        if (fb_r != target) begin
            if (tick_r == 16'(STEP_CYC - 1)) begin
                tick_nxt = 16'h0000;
                if (target > fb_r)
                    fb_nxt = (target - fb_r > `CGPF_STEP_SIZE)
                           ? fb_r + `CGPF_STEP_SIZE : target;
                else
                    fb_nxt = (fb_r - target > `CGPF_STEP_SIZE)
                           ? fb_r - `CGPF_STEP_SIZE : target;
            end else begin
                tick_nxt = tick_r + 16'h0001;
            end
        end else begin
            tick_nxt = 16'h0000;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fb_r       <= `CGPF_VCO_RST;
            tick_r     <= 16'h0000;
            slot_r_act <= `CGPF_SLOT_RST;
        end else begin
            fb_r       <= fb_nxt;
            tick_r     <= tick_nxt;
            slot_r_act <= slot_nxt;
        end
    end
    assign pll2_feedback     = fb_r;
    assign active_slot       = slot_r_act;
    assign overshoot_limiter = (fb_r != target);

    // Spread only exists in PLL1; the others always seed from it.
    assign pll1_spread_on  = ssc_enable;
    assign pll23_seed_pll1 = 1'b1;

    // ------------------------------------------------------------------------
    // Output divider decoding
    // ------------------------------------------------------------------------
    cgpf_div_if d1 ();
    cgpf_div_if d2 ();
    cgpf_div_if d3 ();
    cgpf_div_if d4 ();
    cgpf_div_if d5 ();
    assign d1.code = div1_code;
    assign d2.code = div2_code;
    assign d3.code = div3_code;
    assign d4.code = div4_code;
    assign d5.code = div5_code;
    cgpf_div_decode #(.KIND(0)) u_div1 (.d(d1.dec));
    cgpf_div_decode #(.KIND(1)) u_div2 (.d(d2.dec));
    cgpf_div_decode #(.KIND(1)) u_div3 (.d(d3.dec));
    cgpf_div_decode #(.KIND(2)) u_div4 (.d(d4.dec));
    cgpf_div_decode #(.KIND(1)) u_div5 (.d(d5.dec));
    assign div1_ratio = d1.ratio;
    assign div2_ratio = d2.ratio;
    assign div3_ratio = d3.ratio;
    assign div4_ratio = d4.ratio;
    assign div5_ratio = d5.ratio;
endmodule

// File: cgpf_ctrl_monitor.sv
// Concurrent checks on the ports of the pin function control block.
module cgpf_ctrl_monitor
    import cgpf_pkg::*;
(
    // Clock and reset
    input wire logic           ref_clk,
    input wire logic           rst,
    // Configuration
    input wire logic           freq_select_enable,
    input wire logic           oe23_pin_enable,
    input wire logic           ssc_enable,
    input wire logic [3:0]     div1_code,
    input wire logic [3:0]     div2_code,
    input wire logic [3:0]     div4_code,
    // Status
    input wire logic           latched_pin_select,
    input wire cgpf_ser_role_t serial_role,
    input wire logic           i2c_active,
    input wire logic           out3_enable,
    input wire logic           pll1_spread_on,
    input wire logic           pll23_seed_pll1,
    input wire logic [6:0]     div1_ratio,
    input wire logic [6:0]     div2_ratio,
    input wire logic [6:0]     div4_ratio,
    input wire logic           overshoot_limiter,
    input wire logic [31:0]    pll2_feedback
);
    // ------------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    function automatic logic [6:0] ratio(input int k, input logic [3:0] c);
        logic [6:0] b, m;
        case (c[1:0])
            2'h0: b = 7'h01;
            2'h1: b = (k == 1) ? 7'h04 : 7'h03;
            2'h2: b = 7'h05;
            default: b = (k == 1) ? 7'h06 : 7'h0a;
        endcase
        case (c[3:2])
            2'h0: m = 7'h01;
            2'h1: m = 7'h02;
            2'h2: m = 7'h04;
            default: m = (k == 2) ? 7'h05 : 7'h08;
        endcase
        return b * m;
    endfunction

    // A new target may end the ramp early, so a fall of the flag also counts.
    sequence step_move;
        ##[1:41] (!$stable(pll2_feedback) || !overshoot_limiter);
    endsequence

    i2c_mode_a: assert property (latched_pin_select |->
        serial_role == CGPF_SER_I2C && i2c_active) else $error("i2c role lost");
    oe_mode_a: assert property (!latched_pin_select && oe23_pin_enable |->
        serial_role == CGPF_SER_OE) else $error("enable role wrong");
    fsel_mode_a: assert property (!latched_pin_select && !oe23_pin_enable &&
        freq_select_enable |-> serial_role == CGPF_SER_FSEL) else $error("fsel");
    no_role_a: assert property (!latched_pin_select && !oe23_pin_enable &&
        !freq_select_enable |-> serial_role == CGPF_SER_NONE && out3_enable)
        else $error("idle role wrong");
    latch_hold_a: assert property (!$past(rst) && !$past(rst, 2) |->
        $stable(latched_pin_select)) else $error("latch moved");
    spread_src_a: assert property (pll1_spread_on == ssc_enable &&
        pll23_seed_pll1) else $error("spread source wrong");
    div_one_a: assert property (div1_ratio == ratio(1, div1_code))
        else $error("divider one ratio");
    div_two_a: assert property (div2_ratio == ratio(2, div2_code))
        else $error("divider two ratio");
    div_four_a: assert property (div4_ratio == ratio(4, div4_code))
        else $error("divider four ratio");
    step_size_a: assert property (!$stable(pll2_feedback) |->
        pll2_feedback - $past(pll2_feedback) <= 32'h0000_0100 ||
        $past(pll2_feedback) - pll2_feedback <= 32'h0000_0100)
        else $error("feedback jumped");
    ramp_move_a: assert property (overshoot_limiter |-> step_move)
        else $error("ramp stalled");
endmodule

bind cgpf_ctrl cgpf_ctrl_monitor u_cgpf_ctrl_monitor (.*);

// File: cgpf_div_decode.sv
// Output divider code to ratio decoder for the three divider families.
module cgpf_div_decode #(
    parameter int KIND = 0
) (
    cgpf_div_if.dec d
);
    logic [6:0] base;
    logic [6:0] mult;

    always_comb begin
        case (d.code[1:0])
            2'b00:   base = 7'd1;
            2'b01:   base = (KIND == 0) ? 7'd4 : 7'd3;
            2'b10:   base = 7'd5;
            default: base = (KIND == 0) ? 7'd6 : 7'd10;
        endcase
        case (d.code[3:2])
            2'b00:   mult = 7'd1;
            2'b01:   mult = 7'd2;
            2'b10:   mult = 7'd4;
            default: mult = (KIND == 1) ? 7'd5 : 7'd8;
        endcase
    end

    // Largest product is 80, so seven bits always hold it.
    assign d.ratio = 7'(base * mult);
endmodule

// File: cgpf_div_if.sv
// Interface carrying one output divider's code and its ratio.
interface cgpf_div_if;
    logic [3:0] code;
    logic [6:0] ratio;
    modport dec (input code, output ratio);
    modport use_side (output code, input ratio);
endinterface

// File: cgpf_host_model.sv
// Behavioural system host that drives the control and serial pins.
module cgpf_host_model (
    // Clock
    input  wire logic       ref_clk,
    // Requested levels: first pin, clock pin, data pin, end device down
    input  wire logic [3:0] want,
    // Pins
    output logic            first_ctrl_pin,
    output logic            scl_pin,
    output logic            sda_pin,
    output logic            end_dev_powerdown
);
    // ------------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------------
    // Levels are sampled on the edge and moved just after it, so the clock
    // pin is steady across reset release and the latch sees one value.
    initial {first_ctrl_pin, scl_pin, sda_pin, end_dev_powerdown} = 4'hf;
    always @(posedge ref_clk) begin
        {first_ctrl_pin, scl_pin, sda_pin, end_dev_powerdown} <= #1 want;
    end
endmodule

// File: cgpf_pkg.sv
// Types shared by the clock generator pin function block.
package cgpf_pkg;
    typedef enum logic [1:0] {
        CGPF_SER_NONE,
        CGPF_SER_FSEL,
        CGPF_SER_OE,
        CGPF_SER_I2C
    } cgpf_ser_role_t;
endpackage

// File: tb_cgpf_ctrl.sv
// Self-checking bench for the pin function and divider control block.
module tb_cgpf_ctrl import cgpf_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------------------
    // Signals, models and helpers
    // ------------------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic rst, vco_wr, ssc_enable, freq_select_enable, oe23_pin_enable;
    logic first_ctrl_pin, scl_pin, sda_pin, end_dev_powerdown;
    logic latched_pin_select, i2c_active, out1_enable, out2_enable;
    logic out3_enable, global_powerdown_n, out1_use_32k;
    logic overshoot_limiter, pll1_spread_on, pll23_seed_pll1;
    logic [1:0] first_pin_role_field, reg_freq_select, slot_select, active_slot;
    logic [3:0] div1_code, div2_code, div3_code, div4_code, div5_code, want;
    logic [6:0] div1_ratio, div2_ratio, div3_ratio, div4_ratio, div5_ratio;
    logic [31:0] vco_wdata, pll2_feedback;
    logic [7:0] seed;
    cgpf_ser_role_t serial_role;
    int failures = 0;
    int tests_run = 0;

    cgpf_ctrl u_cgpf_ctrl (.*);
    cgpf_host_model u_cgpf_host_model (.*);

    always #12.5 ref_clk = ~ref_clk;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic logic [6:0] ratio(input int k, input logic [3:0] c);
        logic [6:0] b, m;
        b = (c[1:0] == 0) ? 7'h01 : (c[1:0] == 2) ? 7'h05 :
            (c[1:0] == 1) ? ((k == 1) ? 7'h04 : 7'h03) :
            ((k == 1) ? 7'h06 : 7'h0a);
        m = (c[3:2] == 3) ? ((k == 2) ? 7'h05 : 7'h08) : 7'h01 << c[3:2];
        return b * m;
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        if (failures == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic settle;
        step(2);
        for (int n = 0; overshoot_limiter !== 1'b0; n++) begin
            if (n > 1000) begin
                failures++;
                conclude();
            end
            step(1);
        end
    endtask

    task automatic do_reset(input logic s);
        rst = 1'b1;
        want[2] = s;
        step(6);
        rst = 1'b0;
        step(1);
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    initial begin
        {rst, vco_wr, ssc_enable, freq_select_enable, oe23_pin_enable} = 5'h10;
        {first_pin_role_field, reg_freq_select, slot_select} = 6'h00;
        {div1_code, div2_code, div3_code, div4_code, div5_code} = 20'h0_0000;
        want = 4'hf;
        vco_wdata = 32'h0000_0000;
        seed = 8'h63;
        do_reset(1'b1);
        check(latched_pin_select, 1);
        check(serial_role, CGPF_SER_I2C);
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            first_pin_role_field = i[1:0];
            {want[3], want[0], ssc_enable} = seed[2:0];
            {div1_code, div2_code, div4_code} = {i[3:0], seed};
            {div3_code, div5_code} = {seed[3:0], ~i[3:0]};
            step(3);
            check(out1_enable, i[1:0] != 0 || want[3]);
            check(global_powerdown_n, i[1:0] != 1 || want[3]);
            check(out1_use_32k, i[1:0] == 2 && want[0]);
            check(div1_ratio, ratio(1, div1_code));
            check(div3_ratio, ratio(2, div3_code));
            check(div5_ratio, ratio(2, div5_code));
            check(div4_ratio, ratio(4, div4_code));
        end
        {first_pin_role_field, freq_select_enable, reg_freq_select} = 5'h06;
        for (int k = 0; k < 4; k++) begin
            slot_select = k[1:0];
            vco_wdata = 32'h0000_0100 * (k + 1);
            vco_wr = 1'b1;
            step(1);
        end
        vco_wr = 1'b0;
        check(overshoot_limiter, 1);
        settle();
        check(active_slot, 2);
        check(pll2_feedback, 32'h0000_0300);
        first_pin_role_field = 2'h3;
        for (int k = 1; k >= 0; k--) begin
            want[3] = k[0];
            step(3);
            settle();
            check(active_slot, k);
            check(pll2_feedback, 32'h0000_0100 * (k + 1));
        end
        first_pin_role_field = 2'h0;
        do_reset(1'b0);
        for (int k = 0; k < 4; k++) begin
            want[2:1] = k[1:0];
            {oe23_pin_enable, freq_select_enable} = {1'b1, k[0]};
            step(3);
            check(out3_enable, k[1]);
            check(out2_enable, k[0]);
            {oe23_pin_enable, freq_select_enable} = 2'h1;
            step(2);
            check(active_slot, k);
            freq_select_enable = 1'b0;
            step(1);
            check(serial_role, CGPF_SER_NONE);
        end
        check(latched_pin_select, 0);
        check(i2c_active, 0);
        conclude();
    end
endmodule
